// >>> include/oosc_pkg.sv
// Purpose: Shared constants for the output on/off cross-frame sync block
// Assumes: pclk at 20 MHz, 32-bit APB data, 8 connector lines, 4 channels
// Notes: Delays are counted in 1 ms ticks
package oosc_pkg;
  localparam int N_LINES = 8;
  localparam int N_CH = 4;
  localparam int DLY_W = 16;
  // Only the upper four connector lines may carry a sync function
  localparam logic [7:0] SYNC_LINE_MASK = 8'hF0;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LINEFN = 8'h04;
  localparam logic [7:0] OFS_CHAN = 8'h08;
  localparam logic [7:0] OFS_DOFF = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_MAXOFF = 8'h18;
  localparam logic [7:0] OFS_ONDLY = 8'h20;
  localparam logic [7:0] OFS_OFFDLY = 8'h30;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_KEY_BIT = 1;
  localparam int CMD_ON_BIT = 0;
  localparam int CMD_OFF_BIT = 1;
  localparam int CMD_SRC_LSB = 4;
  localparam int CMD_CH_LSB = 8;

  localparam logic [1:0] FN_NONE = 2'h0;
  localparam logic [1:0] FN_ON = 2'h1;
  localparam logic [1:0] FN_OFF = 2'h2;
  localparam logic [1:0] FN_RSV = 2'h3;

  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [15:0] RST_LINEFN = 16'h0000;
  localparam logic [3:0] RST_CHAN = 4'h0;
  localparam logic [15:0] RST_DLY = 16'h0000;

  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int PULSE_US = 10;
  localparam int PULSE_CYC = CLK_HZ / 1_000_000 * PULSE_US;

  typedef enum logic [0:0] {SQ_IDLE, SQ_OFFSET} oosc_seq_t;
endpackage

// >>> include/oosc_link_if.sv
// Purpose: Shared connector lines between two mainframes
// Assumes: Lines are open drain with a pull-up
// Notes: A line is low while either end enables a low drive
`timescale 1ns/10ps
interface oosc_link_if;
  logic [7:0] dev_out;
  logic [7:0] dev_oe;
  logic [7:0] far_out;
  logic [7:0] far_oe;
  logic [7:0] line;

  assign line = ~((dev_oe & ~dev_out) | (far_oe & ~far_out));

  modport dev (output dev_out, output dev_oe, input line);
  modport far (output far_out, output far_oe, input line);
endinterface

// >>> hdl/oosc_far.sv
// Purpose: Peer mainframe end of the on/off sync link
// Assumes: Inputs synchronous to pclk; one output group per peer
// Notes: Peer channel delays are folded into its common offset
`timescale 1ns/10ps
module oosc_far #(
  parameter int TICK_CYC = oosc_pkg::TICK_CYC,
  parameter int PULSE_CYC = oosc_pkg::PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sync_en,
  input wire logic coupled_any,
  input wire logic [2:0] on_line_sel,
  input wire logic [2:0] off_line_sel,
  input wire logic [15:0] doff_ms,
  input wire logic req_on,
  input wire logic req_off,
  output logic outputs_on,
  output logic on_seen,
  output logic off_seen,
  oosc_link_if.far link
);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int PW = $clog2(PULSE_CYC + 1);

  logic [7:0] s1_q, s2_q, oe_q;
  logic on_prev_q, off_prev_q, wait_q;
  logic [PW-1:0] pon_q, poff_q;
  logic [TW-1:0] tick_q;
  logic [15:0] ofs_q;

  // Takes part only when enabled and owning a coupled channel
  wire part = sync_en & coupled_any;
  wire on_lvl = s2_q[on_line_sel];
  wire off_lvl = s2_q[off_line_sel];
  wire fall_on = part & on_prev_q & ~on_lvl;
  wire fall_off = part & off_prev_q & ~off_lvl;
  wire tick = tick_q == TW'(TICK_CYC - 1);
  wire [7:0] on_bit = 8'h01 << on_line_sel;
  wire [7:0] off_bit = 8'h01 << off_line_sel;

  assign link.far_out = 8'h00;
  assign link.far_oe = oe_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 8'hFF;
      s2_q <= 8'hFF;
      on_prev_q <= 1'b1;
      off_prev_q <= 1'b1;
      oe_q <= 8'h00;
      pon_q <= '0;
      poff_q <= '0;
      tick_q <= '0;
      ofs_q <= 16'h0000;
      wait_q <= 1'b0;
      outputs_on <= 1'b0;
      on_seen <= 1'b0;
      off_seen <= 1'b0;
    end else begin
      s1_q <= link.line;
      s2_q <= s1_q;
      on_prev_q <= on_lvl;
      off_prev_q <= off_lvl;
      tick_q <= tick ? '0 : tick_q + TW'(1);
      on_seen <= fall_on;
      off_seen <= fall_off;
      // A request is a low pulse on the shared line
      if (part & req_on & (pon_q == '0)) begin
        pon_q <= PW'(PULSE_CYC);
      end else if (pon_q != '0) begin
        pon_q <= pon_q - PW'(1);
      end
      if (part & req_off & (poff_q == '0)) begin
        poff_q <= PW'(PULSE_CYC);
      end else if (poff_q != '0) begin
        poff_q <= poff_q - PW'(1);
      end
      oe_q <= ({8{pon_q != '0}} & on_bit) | ({8{poff_q != '0}} & off_bit);
      // Same common offset as every other frame
      if (fall_off) begin
        wait_q <= 1'b0;
        outputs_on <= 1'b0;
      end else if (fall_on) begin
        wait_q <= 1'b1;
        ofs_q <= doff_ms;
      end else if (wait_q & (ofs_q == 16'h0000)) begin
        wait_q <= 1'b0;
        outputs_on <= 1'b1;
      end else if (wait_q & tick) begin
        ofs_q <= ofs_q - 16'h0001;
      end
    end
  end
endmodule

// >>> hdl/oosc_dev.sv
// Purpose: Coupled output on/off sequencing across mainframes
// Assumes: APB slave, one wait-free access phase; pclk at 20 MHz
// Notes: Delays count in 1 ms ticks; first tick may come early
`timescale 1ns/10ps
// Behaviour
// - Sync functions only on upper four lines
// - Refuse duplicate on or off line functions
// - Line polarity fixed, not configurable
// - Sync line both driven and monitored
// - Falling edge is the sync event
// - Event switches all coupled channels after delays
// - Key, web, remote commands act alike
// - Key coupling also switches uncoupled channels
// - Each synced frame has a coupled channel
// - Each synced frame enables cross-frame sync
// - Same common offset, largest, on all frames
// - Report slowest module offset on query
// - Lines and commons wired across frames
// - Turn-on waits common offset, then delays
// - Turn-off starts channel delays at once
module oosc_dev #(
  parameter int TICK_CYC = oosc_pkg::TICK_CYC,
  parameter int PULSE_CYC = oosc_pkg::PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [oosc_pkg::N_CH*16-1:0] module_offset_us,
  output logic [oosc_pkg::N_CH-1:0] chan_on,
  oosc_link_if.dev link
);
  localparam int NL = oosc_pkg::N_LINES;
  localparam int NC = oosc_pkg::N_CH;
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int PW = $clog2(PULSE_CYC + 1);

  logic [1:0] ctrl_q;
  logic [15:0] fn_q;
  logic [NC-1:0] chan_q;
  logic [15:0] doff_q;
  logic [15:0] ond_q [NC];
  logic [15:0] offd_q [NC];
  logic [NL-1:0] s1_q, s2_q, oe_q;
  logic on_prev_q, off_prev_q, go_q;
  logic [PW-1:0] pon_q, poff_q;
  logic [TW-1:0] tick_q;
  logic [15:0] ofs_q;
  oosc_pkg::oosc_seq_t seq_q;
  logic [2:0] on_idx;
  logic [2:0] off_idx;
  logic [15:0] max_off;

  // Bus decode
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire wr_ctrl = wr & (paddr == oosc_pkg::OFS_CTRL);
  wire wr_fn = wr & (paddr == oosc_pkg::OFS_LINEFN);
  wire wr_chan = wr & (paddr == oosc_pkg::OFS_CHAN);
  wire wr_doff = wr & (paddr == oosc_pkg::OFS_DOFF);
  wire wr_cmd = wr & (paddr == oosc_pkg::OFS_CMD);
  wire in_ond = paddr[7:4] == oosc_pkg::OFS_ONDLY[7:4];
  wire in_offd = paddr[7:4] == oosc_pkg::OFS_OFFDLY[7:4];
  wire [1:0] dsel = paddr[3:2];

  // Line function check on the written word; the held one is only decoded
  wire [NL-1:0] w_on;
  wire [NL-1:0] w_off;
  wire [NL-1:0] w_rsv;
  wire [NL-1:0] w_used;
  wire [NL-1:0] f_on;
  wire [NL-1:0] f_off;
  for (genvar i = 0; i < NL; i++) begin : g_fn
    assign w_on[i] = pwdata[2*i +: 2] == oosc_pkg::FN_ON;
    assign w_off[i] = pwdata[2*i +: 2] == oosc_pkg::FN_OFF;
    assign w_rsv[i] = pwdata[2*i +: 2] == oosc_pkg::FN_RSV;
    assign w_used[i] = pwdata[2*i +: 2] != oosc_pkg::FN_NONE;
    assign f_on[i] = fn_q[2*i +: 2] == oosc_pkg::FN_ON;
    assign f_off[i] = fn_q[2*i +: 2] == oosc_pkg::FN_OFF;
  end
  wire fn_upper = (w_used & ~oosc_pkg::SYNC_LINE_MASK) == '0;
  wire fn_single = $onehot0(w_on) & $onehot0(w_off);
  wire fn_ok = fn_upper & fn_single & (w_rsv == '0);

  always_comb begin
    on_idx = 3'h0;
    off_idx = 3'h0;
    for (int i = 0; i < NL; i++) begin
      if (f_on[i]) begin
        on_idx = 3'(i);
      end
      if (f_off[i]) begin
        off_idx = 3'(i);
      end
    end
  end

  // Reported in microseconds, the unit of the module inputs
  always_comb begin
    max_off = 16'h0000;
    for (int i = 0; i < NC; i++) begin
      if (module_offset_us[16*i +: 16] > max_off) begin
        max_off = module_offset_us[16*i +: 16];
      end
    end
  end

  wire [31:0] rd_mux =
    (paddr == oosc_pkg::OFS_CTRL) ? {30'h0, ctrl_q} :
    (paddr == oosc_pkg::OFS_LINEFN) ? {16'h0, fn_q} :
    (paddr == oosc_pkg::OFS_CHAN) ? {{(32-NC){1'b0}}, chan_q} :
    (paddr == oosc_pkg::OFS_DOFF) ? {16'h0, doff_q} :
    (paddr == oosc_pkg::OFS_STAT) ? {{(32-NC){1'b0}}, chan_on} :
    (paddr == oosc_pkg::OFS_MAXOFF) ? {16'h0, max_off} :
    in_ond ? {16'h0, ond_q[dsel]} :
    in_offd ? {16'h0, offd_q[dsel]} :
    32'h0000_0000;

  // Commands and events
  wire en = ctrl_q[oosc_pkg::CTRL_EN_BIT];
  wire key = ctrl_q[oosc_pkg::CTRL_KEY_BIT];
  wire cmd_on = wr_cmd & pwdata[oosc_pkg::CMD_ON_BIT];
  wire cmd_off = wr_cmd & pwdata[oosc_pkg::CMD_OFF_BIT];
  wire [1:0] cmd_ch = pwdata[oosc_pkg::CMD_CH_LSB +: 2];
  // Source field ignored on purpose: key, web and remote act alike
  wire cmd_cpl = chan_q[cmd_ch];
  wire x_on = en & (|f_on);
  wire x_off = en & (|f_off);
  wire lc_on = cmd_on & cmd_cpl;
  wire lc_off = cmd_off & cmd_cpl;
  wire on_lvl = s2_q[on_idx];
  wire off_lvl = s2_q[off_idx];
  // Polarity fixed: only a falling edge counts, no setting
  wire fall_on = x_on & on_prev_q & ~on_lvl;
  wire fall_off = x_off & off_prev_q & ~off_lvl;
  wire ev_on = fall_on | (lc_on & ~x_on);
  wire ev_off = fall_off | (lc_off & ~x_off);
  wire tick = tick_q == TW'(TICK_CYC - 1);
  wire in_ofs = seq_q == oosc_pkg::SQ_OFFSET;
  wire ofs_done = in_ofs & (ofs_q == 16'h0000);
  wire start_on = ofs_done & ~ev_off & ~ev_on;
  wire start_off = ev_off;
  wire [NC-1:0] grp = key ? '1 : chan_q;
  wire [NC-1:0] ch_bit = NC'(1) << cmd_ch;
  wire [NC-1:0] dir_on = (cmd_on & ~cmd_cpl) ? ch_bit : '0;
  wire [NC-1:0] dir_off = (cmd_off & ~cmd_cpl) ? ch_bit : '0;
  wire [NL-1:0] on_bit = NL'(1) << on_idx;
  wire [NL-1:0] off_bit = NL'(1) << off_idx;
  wire [NC-1:0] ch_on_w;

  // Released or pulled low only, so frames can share a wire
  assign link.dev_out = '0;
  assign link.dev_oe = oe_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      ctrl_q <= oosc_pkg::RST_CTRL;
      fn_q <= oosc_pkg::RST_LINEFN;
      chan_q <= oosc_pkg::RST_CHAN;
      doff_q <= oosc_pkg::RST_DLY;
      for (int i = 0; i < NC; i++) begin
        ond_q[i] <= oosc_pkg::RST_DLY;
        offd_q[i] <= oosc_pkg::RST_DLY;
      end
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= rd_mux;
        pslverr <= pwrite & (paddr == oosc_pkg::OFS_LINEFN) & ~fn_ok;
      end
      if (wr_ctrl) begin
        ctrl_q <= pwdata[1:0];
      end
      // A refused setting keeps the old one
      if (wr_fn & fn_ok) begin
        fn_q <= pwdata[15:0];
      end
      if (wr_chan) begin
        chan_q <= pwdata[NC-1:0];
      end
      if (wr_doff) begin
        doff_q <= pwdata[15:0];
      end
      if (wr & in_ond) begin
        ond_q[dsel] <= pwdata[15:0];
      end
      if (wr & in_offd) begin
        offd_q[dsel] <= pwdata[15:0];
      end
    end
  end

  // Two-stage synchroniser ahead of the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '1;
      s2_q <= '1;
      on_prev_q <= 1'b1;
      off_prev_q <= 1'b1;
      oe_q <= '0;
      pon_q <= '0;
      poff_q <= '0;
    end else begin
      s1_q <= link.line;
      s2_q <= s1_q;
      on_prev_q <= on_lvl;
      off_prev_q <= off_lvl;
      if (x_on & lc_on & (pon_q == '0)) begin
        pon_q <= PW'(PULSE_CYC);
      end else if (pon_q != '0) begin
        pon_q <= pon_q - PW'(1);
      end
      if (x_off & lc_off & (poff_q == '0)) begin
        poff_q <= PW'(PULSE_CYC);
      end else if (poff_q != '0) begin
        poff_q <= poff_q - PW'(1);
      end
      oe_q <= ({NL{pon_q != '0}} & on_bit) | ({NL{poff_q != '0}} & off_bit);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= oosc_pkg::SQ_IDLE;
      ofs_q <= 16'h0000;
      tick_q <= '0;
      chan_on <= '0;
    end else begin
      tick_q <= tick ? '0 : tick_q + TW'(1);
      chan_on <= ch_on_w;
      unique case (seq_q)
        oosc_pkg::SQ_IDLE: begin
          if (ev_on & ~ev_off) begin
            seq_q <= oosc_pkg::SQ_OFFSET;
            ofs_q <= doff_q;
          end
        end
        oosc_pkg::SQ_OFFSET: begin
          if (ev_off | start_on) begin
            seq_q <= oosc_pkg::SQ_IDLE;
          end else if (ev_on) begin
            ofs_q <= doff_q;
          end else if (tick) begin
            ofs_q <= ofs_q - 16'h0001;
          end
        end
      endcase
    end
  end

  // Per-channel delay; turn-off skips the common offset
  for (genvar i = 0; i < NC; i++) begin : g_ch
    logic [15:0] cnt_q;
    logic pend_q;
    logic tgt_q;
    logic on_q;
    wire ld_on = start_on & grp[i];
    wire ld_off = start_off & grp[i];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q <= 16'h0000;
        pend_q <= 1'b0;
        tgt_q <= 1'b0;
        on_q <= 1'b0;
      end else if (ld_off) begin
        cnt_q <= offd_q[i];
        pend_q <= 1'b1;
        tgt_q <= 1'b0;
      end else if (ld_on) begin
        cnt_q <= ond_q[i];
        pend_q <= 1'b1;
        tgt_q <= 1'b1;
      end else if (dir_on[i] | dir_off[i]) begin
        on_q <= dir_on[i];
        pend_q <= 1'b0;
      end else if (pend_q & (cnt_q == 16'h0000)) begin
        on_q <= tgt_q;
        pend_q <= 1'b0;
      end else if (pend_q & tick) begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
    assign ch_on_w[i] = on_q;
  end
endmodule

// >>> verification/oosc_link_props.sv
// Purpose: Checks on the shared sync lines between two ends
// Assumes: Both ends run on pclk
// Notes: Drive is low or released; pulses are short
`timescale 1ns/10ps
module oosc_link_props #(
  parameter int PULSE_CYC = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] dev_out,
  input wire logic [7:0] dev_oe,
  input wire logic [7:0] far_out,
  input wire logic [7:0] far_oe,
  input wire logic [7:0] line
);
  localparam int PW_MAX = PULSE_CYC + 2;
  wire logic [7:0] dlo = dev_oe & ~dev_out;
  wire logic [7:0] flo = far_oe & ~far_out;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence dev_pull_s; $rose(|dlo); endsequence
  sequence far_pull_s; $rose(|flo); endsequence
  dev_low_only_a: assert property ((dev_oe & dev_out) == 8'h00)
    else $error("dev drives a line high");
  far_low_only_a: assert property ((far_oe & far_out) == 8'h00)
    else $error("far drives a line high");
  dev_upper_lines_a: assert property (dev_oe[3:0] == 4'h0)
    else $error("dev drives a lower line");
  far_upper_lines_a: assert property (far_oe[3:0] == 4'h0)
    else $error("far drives a lower line");
  dev_two_lines_a: assert property ($countones(dev_oe) <= 2)
    else $error("dev drives more than two lines");
  dev_pulse_ends_a: assert property (dev_pull_s |-> ##[1:PW_MAX] !(|dlo))
    else $error("dev pulse too long");
  dev_pulse_held_a: assert property (dev_pull_s |-> (|dlo) [*2])
    else $error("dev pulse too short");
  far_pulse_ends_a: assert property (far_pull_s |-> ##[1:PW_MAX] !(|flo))
    else $error("far pulse too long");
  line_level_a: assert property (line == ~(dlo | flo))
    else $error("line level wrong");
endmodule

// >>> verification/output_onoff_cross_sync_tb.sv
// Purpose: Bench joining the device end and the peer end
// Assumes: Short tick and pulse counts to keep the run brief
// Notes: Refused line settings are expected to leave the old value
`timescale 1ns/10ps
module output_onoff_cross_sync_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, req_on = 0, req_off = 0, f_on, f_ons, f_offs;
  logic [3:0] chan_on;
  logic sync_en = 1, cpl = 1;
  logic [2:0] on_sel = 3'h6, off_sel = 3'h7;
  logic [15:0] f_doff = 16'h0000;
  logic [63:0] mod_off = 64'h0010_0020_0030_0040;
  logic [39:0] rows [5];
  int fail_count = 0, checked = 0, cyc = 0;
  oosc_link_if link ();
  oosc_dev #(.TICK_CYC(20), .PULSE_CYC(4)) oosc_dev_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .module_offset_us(mod_off),
    .chan_on(chan_on), .link(link.dev));
  oosc_far #(.TICK_CYC(20), .PULSE_CYC(4)) oosc_far_i (.pclk(pclk),
    .presetn(presetn), .sync_en(sync_en), .coupled_any(cpl),
    .on_line_sel(on_sel), .off_line_sel(off_sel), .doff_ms(f_doff),
    .req_on(req_on), .req_off(req_off), .outputs_on(f_on),
    .on_seen(f_ons), .off_seen(f_offs), .link(link.far));
  oosc_link_props #(.PULSE_CYC(4)) oosc_link_props_i (.pclk(pclk),
    .presetn(presetn), .dev_out(link.dev_out), .dev_oe(link.dev_oe),
    .far_out(link.far_out), .far_oe(link.far_oe), .line(link.line));
  always #25 pclk = ~pclk;
  task end_sim();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      end_sim();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wt(input logic [3:0] e, input logic fe);
    for (int i = 0; i < 3000 && (chan_on !== e || f_on !== fe); i++)
      @(posedge pclk);
    chk("chan_on", {28'h0, e}, {28'h0, chan_on});
    chk("outputs_on", {31'h0, fe}, {31'h0, f_on});
  endtask
  initial begin
    rows = '{{oosc_pkg::OFS_CTRL, 32'h0}, {oosc_pkg::OFS_LINEFN, 32'h0},
      {oosc_pkg::OFS_CHAN, 32'h0}, {oosc_pkg::OFS_DOFF, 32'h0},
      {oosc_pkg::OFS_ONDLY, 32'h0}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(1'b0, rows[i][39:32], 32'h0);
      chk("reset value", rows[i][31:0], r);
    end
    $display("reset values done");
    apb(1'b1, oosc_pkg::OFS_LINEFN, 32'h9000);
    apb(1'b1, oosc_pkg::OFS_LINEFN, 32'h0001);
    apb(1'b1, oosc_pkg::OFS_LINEFN, 32'h5000);
    apb(1'b0, oosc_pkg::OFS_LINEFN, 32'h0);
    chk("linefn", 32'h9000, r);
    apb(1'b1, oosc_pkg::OFS_CHAN, 32'hF);
    apb(1'b1, oosc_pkg::OFS_CTRL, 32'h1);
    $display("config done");
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, oosc_pkg::OFS_CMD, 32'h1 | (s << 4));
      wt(4'hF, 1'b1);
      apb(1'b1, oosc_pkg::OFS_CMD, 32'h2 | (s << 4));
      wt(4'h0, 1'b0);
    end
    $display("local commands done");
    req_on <= 1'b1;
    @(posedge pclk);
    req_on <= 1'b0;
    wt(4'hF, 1'b1);
    req_off <= 1'b1;
    @(posedge pclk);
    req_off <= 1'b0;
    wt(4'h0, 1'b0);
    $display("peer events done");
    apb(1'b0, oosc_pkg::OFS_STAT, 32'h0);
    chk("stat", 32'h0, r);
    apb(1'b0, oosc_pkg::OFS_MAXOFF, 32'h0);
    chk("maxoff", 32'h40, r);
    for (int i = 0; i < 4; i++)
      apb(1'b1, oosc_pkg::OFS_ONDLY + 8'(4 * i), i);
    apb(1'b1, oosc_pkg::OFS_DOFF, 32'h3);
    f_doff <= 16'h0003;
    apb(1'b1, oosc_pkg::OFS_CMD, 32'h1);
    repeat (30) @(posedge pclk);
    chk("chan_on in offset", 32'h0, {28'h0, chan_on});
    wt(4'h1, 1'b1);
    wt(4'h3, 1'b1);
    wt(4'h7, 1'b1);
    wt(4'hF, 1'b1);
    apb(1'b1, oosc_pkg::OFS_CMD, 32'h2);
    repeat (12) @(posedge pclk);
    chk("chan_on off at once", 32'h0, {28'h0, chan_on});
    $display("delay tests done");
    apb(1'b1, oosc_pkg::OFS_CHAN, 32'h3);
    apb(1'b1, oosc_pkg::OFS_CTRL, 32'h3);
    apb(1'b1, oosc_pkg::OFS_CMD, 32'h1);
    wt(4'hF, 1'b1);
    apb(1'b1, oosc_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, oosc_pkg::OFS_CMD, 32'h2);
    wt(4'hC, 1'b0);
    apb(1'b1, oosc_pkg::OFS_CMD, 32'h302);
    wt(4'h4, 1'b0);
    apb(1'b1, oosc_pkg::OFS_CMD, 32'h202);
    wt(4'h0, 1'b0);
    $display("key coupling done");
    sync_en <= 1'b0;
    apb(1'b1, oosc_pkg::OFS_CMD, 32'h1);
    wt(4'h3, 1'b0);
    apb(1'b1, oosc_pkg::OFS_CMD, 32'h2);
    wt(4'h0, 1'b0);
    sync_en <= 1'b1;
    $display("sync disable done");
    end_sim();
  end
endmodule
